/* File: rtl/ebt_bus_ctrl.v */
// external bus cycle sequencer with wishbone register port
//
// Functional notes
// - each cycle runs address setup, command delay, write setup, access, hold in that order.
// - address setup is one or two steps plus zero to three more on a window change.
// - phase lengths come from a per chip-select timing config; command delay is 0 to 3 steps.
// - write setup or multiplexed tristate phase lasts zero or one step.
// - access lasts 1 to 32 steps, or its end is governed by the ready input.
// - the address and write data hold phase lasts zero to three steps.
// - above 80 MHz system clock, steps stretch so bus output edges are at least 12.5 ns apart.
// - when enabled, the reference clock output pulses high for one system clock once per timing step.
// - ready polarity is selectable; asynchronous ready adds at least one waitstate.
// - ready sampled inactive inserts a waitstate; sampled active ends the access phase, and the hold phase follows when nonzero.
//
// Chosen here: the Wishbone register port and the register offsets.
`include "ebt_defines.vh"

module ebt_bus_ctrl (
  input  wire        clock_i,
  input  wire        reset_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg  [23:0] ebus_addr_o,
  output reg  [15:0] ebus_data_o,
  output reg         ebus_data_oe_o,
  input  wire [15:0] ebus_data_i,
  output reg  [1:0]  ebus_cs_n_o,
  output reg         ebus_ale_o,
  output reg         ebus_rd_n_o,
  output reg         ebus_wr_n_o,
  input  wire        ebus_ready_i,
  output reg         bus_reference_clock_out_o
);

  localparam integer STEP_CYCLES = `EBT_STEP_CYCLES;
  localparam [1:0]   STEP_LAST   = STEP_CYCLES[1:0] - 2'h1;

  ////////////////////////////////////////////////////////////////////////////
  // registers and wires
  reg  [1:0]                 step_cnt_reg;
  reg                        step_en;
  reg  [`EBT_CFG_BITS-1:0]   tcfg0_reg;
  reg  [`EBT_CFG_BITS-1:0]   tcfg1_reg;
  reg                        bus_reference_clock_out_en_reg;
  reg  [23:0]                addr_reg;
  reg  [15:0]                wdata_reg;
  reg  [15:0]                rdata_reg;
  reg  [1:0]                 rd_cap_reg;
  reg                        done_reg;
  reg                        start_reg;
  reg                        write_reg;
  reg                        cs_reg;
  reg                        last_cs_reg;
  reg  [`EBT_CFG_BITS-1:0]   cur_cfg_reg;
  reg  [2:0]                 state_reg;
  reg  [2:0]                 state_next;
  reg  [5:0]                 cnt_reg;
  reg  [5:0]                 cnt_next;
  reg                        finish;
  reg  [31:0]                rd_mux;
  wire [15:0]                data_sync;
  wire                       ready_sync;
  wire                       ready_active;
  wire                       wb_req;
  wire                       wb_wr;
  wire [5:0]                 wb_ofs;
  wire [31:0]                wmask;
  wire [31:0]                wval;
  wire                       busy;
  wire                       win_change;
  wire [`EBT_CFG_BITS-1:0]   sel_cfg;
  wire [5:0]                 ab_len;
  wire [5:0]                 c_len;
  wire [5:0]                 d_len;
  wire [5:0]                 e_len;
  wire [5:0]                 f_len;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  ebt_sync2 #(
    .WIDTH (16)
  ) u_data_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .async_i (ebus_data_i),
    .sync_o  (data_sync)
  );

  ebt_sync2 #(
    .WIDTH (1)
  ) u_ready_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .async_i (ebus_ready_i),
    .sync_o  (ready_sync)
  );

  assign ready_active = ~(ready_sync ^ cur_cfg_reg[`EBT_F_RDY_POL]);

  ////////////////////////////////////////////////////////////////////////////
  // timing step divider: every phase edge lands on a step
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      step_cnt_reg <= 2'h0;
      step_en      <= 1'b0;
    end else begin
      step_en <= (step_cnt_reg == STEP_LAST);
      if (step_cnt_reg == STEP_LAST) begin
        step_cnt_reg <= 2'h0;
      end else begin
        step_cnt_reg <= step_cnt_reg + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave, one wait cycle per access
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;
  assign wb_ofs = wb_adr_i[7:2];
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign busy   = start_reg | (state_reg != `EBT_ST_IDLE);

  always @* begin
    case (wb_ofs)
      `EBT_OFS_TCFG0:  rd_mux = {16'h0000, tcfg0_reg};
      `EBT_OFS_TCFG1:  rd_mux = {16'h0000, tcfg1_reg};
      `EBT_OFS_CTRL:   rd_mux = {31'h00000000, bus_reference_clock_out_en_reg};
      `EBT_OFS_ADDR:   rd_mux = {8'h00, addr_reg};
      `EBT_OFS_WDATA:  rd_mux = {16'h0000, wdata_reg};
      `EBT_OFS_CMD:    rd_mux = {30'h00000000, cs_reg, write_reg};
      `EBT_OFS_RDATA:  rd_mux = {16'h0000, rdata_reg};
      `EBT_OFS_STATUS: rd_mux = {29'h00000000, last_cs_reg, done_reg, busy};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // merge of byte lanes into the current register value
  assign wval = (wb_dat_i & wmask) | (rd_mux & ~wmask);

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h00000000;
      tcfg0_reg     <= `EBT_RST_CFG;
      tcfg1_reg     <= `EBT_RST_CFG;
      bus_reference_clock_out_en_reg <= `EBT_RST_CTRL;
      addr_reg      <= 24'h000000;
      wdata_reg     <= 16'h0000;
      write_reg     <= 1'b0;
      cs_reg        <= 1'b0;
      start_reg     <= 1'b0;
      done_reg      <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : 32'h00000000;
      if (wb_wr && !busy) begin
        case (wb_ofs)
          `EBT_OFS_TCFG0: tcfg0_reg <= wval[`EBT_CFG_BITS-1:0];
          `EBT_OFS_TCFG1: tcfg1_reg <= wval[`EBT_CFG_BITS-1:0];
          `EBT_OFS_ADDR:  addr_reg  <= wval[23:0];
          `EBT_OFS_WDATA: wdata_reg <= wval[15:0];
          default: ;
        endcase
      end
      if (wb_wr && (wb_ofs == `EBT_OFS_CTRL)) begin
        bus_reference_clock_out_en_reg <= wval[`EBT_F_BUS_REFERENCE_CLOCK_OUT_EN];
      end
      // a command while a cycle runs is dropped
      if (wb_wr && !busy && (wb_ofs == `EBT_OFS_CMD) && wb_sel_i[0]) begin
        write_reg <= wb_dat_i[`EBT_F_CMD_WRITE];
        cs_reg    <= wb_dat_i[`EBT_F_CMD_CS];
        start_reg <= 1'b1;
      end else if (step_en && (state_reg == `EBT_ST_IDLE)) begin
        start_reg <= 1'b0;
      end
      // completion wins over a clear in the same cycle
      if (finish) begin
        done_reg <= 1'b1;
      end else if (wb_wr && (wb_ofs == `EBT_OFS_STATUS) && wb_sel_i[0] &&
                   wb_dat_i[`EBT_F_ST_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase lengths in timing steps
  assign sel_cfg    = cs_reg ? tcfg1_reg : tcfg0_reg;
  assign win_change = (cs_reg != last_cs_reg);
  assign ab_len     = `EBT_AB_MIN + {5'h00, sel_cfg[`EBT_F_AB_BASE]} +
                      (win_change ? {4'h0, sel_cfg[`EBT_F_WIN_HI:`EBT_F_WIN_LO]} :
                       `EBT_CNT_ZERO);
  assign c_len      = {4'h0, cur_cfg_reg[`EBT_F_CMD_HI:`EBT_F_CMD_LO]};
  assign d_len      = {5'h00, cur_cfg_reg[`EBT_F_WSET]};
  assign e_len      = {1'b0, cur_cfg_reg[`EBT_F_ACC_HI:`EBT_F_ACC_LO]} + `EBT_ACC_MIN;
  assign f_len      = {4'h0, cur_cfg_reg[`EBT_F_HOLD_HI:`EBT_F_HOLD_LO]};

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencer; counter holds steps left minus one
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    finish     = 1'b0;
    if (step_en) begin
      case (state_reg)
        `EBT_ST_IDLE: begin
          if (start_reg) begin
            state_next = `EBT_ST_AB;
            cnt_next   = ab_len - `EBT_CNT_ONE;
          end
        end
        `EBT_ST_AB, `EBT_ST_C, `EBT_ST_D: begin
          if (cnt_reg != `EBT_CNT_ZERO) begin
            cnt_next = cnt_reg - `EBT_CNT_ONE;
          end else if ((state_reg == `EBT_ST_AB) && (c_len != `EBT_CNT_ZERO)) begin
            state_next = `EBT_ST_C;
            cnt_next   = c_len - `EBT_CNT_ONE;
          end else if ((state_reg != `EBT_ST_D) && (d_len != `EBT_CNT_ZERO)) begin
            state_next = `EBT_ST_D;
            cnt_next   = d_len - `EBT_CNT_ONE;
          end else begin
            state_next = `EBT_ST_E;
            cnt_next   = e_len - `EBT_CNT_ONE;
          end
        end
        `EBT_ST_E, `EBT_ST_RDY: begin
          if ((state_reg == `EBT_ST_E) && (cnt_reg != `EBT_CNT_ZERO)) begin
            cnt_next = cnt_reg - `EBT_CNT_ONE;
          end else if (cur_cfg_reg[`EBT_F_RDY_EN] &&
                       (((state_reg == `EBT_ST_E) && cur_cfg_reg[`EBT_F_RDY_ASYNC]) ||
                        !ready_active)) begin
            state_next = `EBT_ST_RDY;
          end else if (f_len != `EBT_CNT_ZERO) begin
            state_next = `EBT_ST_F;
            cnt_next   = f_len - `EBT_CNT_ONE;
          end else begin
            state_next = `EBT_ST_IDLE;
            finish     = 1'b1;
          end
        end
        `EBT_ST_F: begin
          if (cnt_reg != `EBT_CNT_ZERO) begin
            cnt_next = cnt_reg - `EBT_CNT_ONE;
          end else begin
            state_next = `EBT_ST_IDLE;
            finish     = 1'b1;
          end
        end
        default: begin
          state_next = `EBT_ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg   <= `EBT_ST_IDLE;
      cnt_reg     <= `EBT_CNT_ZERO;
      cur_cfg_reg <= `EBT_RST_CFG;
      last_cs_reg <= 1'b0;
      rdata_reg   <= 16'h0000;
      rd_cap_reg  <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      // config is frozen for the whole cycle
      if (step_en && (state_reg == `EBT_ST_IDLE) && start_reg) begin
        cur_cfg_reg <= sel_cfg;
        last_cs_reg <= cs_reg;
      end
      // pin value at the edge that ends the command reaches data_sync two clocks later,
      // so a one-step access still returns the addressed word
      rd_cap_reg[0] <= step_en && !write_reg &&
                       ((state_reg == `EBT_ST_E) || (state_reg == `EBT_ST_RDY)) &&
                       (state_next != state_reg) && (state_next != `EBT_ST_RDY);
      rd_cap_reg[1] <= rd_cap_reg[0];
      if (rd_cap_reg[1]) begin
        rdata_reg <= data_sync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus pins, registered from the next state so edges follow the steps
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ebus_addr_o               <= 24'h000000;
      ebus_data_o               <= 16'h0000;
      ebus_data_oe_o            <= 1'b0;
      ebus_cs_n_o               <= 2'h3;
      ebus_ale_o                <= 1'b0;
      ebus_rd_n_o               <= 1'b1;
      ebus_wr_n_o               <= 1'b1;
      bus_reference_clock_out_o <= 1'b0;
    end else begin
      ebus_addr_o    <= addr_reg;
      ebus_data_o    <= wdata_reg;
      ebus_ale_o     <= (state_next == `EBT_ST_AB);
      ebus_cs_n_o[0] <= ~((state_next != `EBT_ST_IDLE) && !cs_reg);
      ebus_cs_n_o[1] <= ~((state_next != `EBT_ST_IDLE) && cs_reg);
      ebus_rd_n_o    <= ~(!write_reg &&
                          ((state_next == `EBT_ST_E) || (state_next == `EBT_ST_RDY)));
      ebus_wr_n_o    <= ~(write_reg &&
                          ((state_next == `EBT_ST_E) || (state_next == `EBT_ST_RDY)));
      // write data stays driven through the hold phase
      ebus_data_oe_o <= write_reg && ((state_next == `EBT_ST_D) ||
                        (state_next == `EBT_ST_E) || (state_next == `EBT_ST_RDY) ||
                        (state_next == `EBT_ST_F));
      // flop output: period is one timing step, not one system clock
      bus_reference_clock_out_o <= bus_reference_clock_out_en_reg && (step_cnt_reg == STEP_LAST);
    end
  end

endmodule // ebt_bus_ctrl

/* File: rtl/ebt_defines.vh */
// constants for the external bus cycle timing sequencer
`ifndef EBT_DEFINES_VH
`define EBT_DEFINES_VH

// clock and edge spacing
`define EBT_CLK_PS          8000
`define EBT_SYS_KHZ         125000
`define EBT_FAST_KHZ        80000
`define EBT_MIN_EDGE_PS     12500
`define EBT_STEP_CYCLES     (((`EBT_SYS_KHZ) > (`EBT_FAST_KHZ)) ? \
  (((`EBT_MIN_EDGE_PS) + (`EBT_CLK_PS) - 1) / (`EBT_CLK_PS)) : 1)

// register word offsets (byte address bits 7:2)
`define EBT_OFS_TCFG0       6'h00
`define EBT_OFS_TCFG1       6'h01
`define EBT_OFS_CTRL        6'h02
`define EBT_OFS_ADDR        6'h03
`define EBT_OFS_WDATA       6'h04
`define EBT_OFS_CMD         6'h05
`define EBT_OFS_RDATA       6'h06
`define EBT_OFS_STATUS      6'h07

// chip_select_timing_config fields
`define EBT_F_AB_BASE       0
`define EBT_F_CMD_LO        1
`define EBT_F_CMD_HI        2
`define EBT_F_WSET          3
`define EBT_F_ACC_LO        4
`define EBT_F_ACC_HI        8
`define EBT_F_HOLD_LO       9
`define EBT_F_HOLD_HI       10
`define EBT_F_RDY_EN        11
`define EBT_F_RDY_POL       12
`define EBT_F_RDY_ASYNC     13
`define EBT_F_WIN_LO        14
`define EBT_F_WIN_HI        15
`define EBT_CFG_BITS        16

// control, command and status bits
`define EBT_F_BUS_REFERENCE_CLOCK_OUT_EN     0
`define EBT_F_CMD_WRITE     0
`define EBT_F_CMD_CS        1
`define EBT_F_ST_BUSY       0
`define EBT_F_ST_DONE       1
`define EBT_F_ST_LASTCS     2

// reset values and minima
`define EBT_RST_CFG         16'h0000
`define EBT_RST_CTRL        1'h0
`define EBT_AB_MIN          6'h01
`define EBT_ACC_MIN         6'h01
`define EBT_CNT_ONE         6'h01
`define EBT_CNT_ZERO        6'h00

// sequencer states
`define EBT_ST_IDLE         3'h0
`define EBT_ST_AB           3'h1
`define EBT_ST_C            3'h2
`define EBT_ST_D            3'h3
`define EBT_ST_E            3'h4
`define EBT_ST_RDY          3'h5
`define EBT_ST_F            3'h6

`endif

/* File: rtl/ebt_sync2.v */
// two flip-flop synchroniser for pin inputs
module ebt_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             clock_i,
  input  wire             reset_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // first stage feeds only the second
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // ebt_sync2

/* File: dv/ebt_chk_asserts.sv */
// pin assertions for the external bus sequencer
module ebt_chk (
  input wire logic       clock_i,
  input wire logic       reset_i,
  input wire logic [1:0] ebus_cs_n_o,
  input wire logic       ebus_ale_o,
  input wire logic       ebus_rd_n_o,
  input wire logic       ebus_wr_n_o,
  input wire logic       ebus_data_oe_o,
  input wire logic       bus_reference_clock_out_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire cmd = !(ebus_rd_n_o && ebus_wr_n_o);
  wire sel = (ebus_cs_n_o != 2'b11);
  wire [4:0] pins = {ebus_cs_n_o, ebus_ale_o, ebus_rd_n_o, ebus_wr_n_o};
  sequence cmd_go; $rose(cmd); endsequence
  sequence cmd_end; $fell(cmd); endsequence
  // pins may only move on step boundaries, two clocks apart
  property step_hold; $changed(pins) |=> $stable(pins); endproperty
  ////////////////////////////////////////
  a_ale_first: assert property ($rose(ebus_ale_o) |-> sel && !cmd)
    else $error("ale rose outside setup");
  a_setup_min: assert property ($rose(ebus_ale_o) |-> ebus_ale_o[*2])
    else $error("setup under one step");
  a_setup_max: assert property ($rose(ebus_ale_o) |-> ##[2:10] !ebus_ale_o)
    else $error("setup over five steps");
  a_access_max: assert property (cmd_go |-> ##[2:160] !cmd)
    else $error("access did not end");
  a_hold_max: assert property (cmd_end |-> ##[0:6] !sel)
    else $error("hold over three steps");
  a_write_drive: assert property (cmd |-> ebus_data_oe_o == !ebus_wr_n_o)
    else $error("data drive wrong for direction");
  a_step_edges: assert property (step_hold)
    else $error("pin moved inside a step");
  a_refclk_pulse: assert property (bus_reference_clock_out_o |=> !bus_reference_clock_out_o)
    else $error("refclk high two clocks");
endmodule // ebt_chk

bind ebt_bus_ctrl ebt_chk u_chk (.clock_i, .reset_i, .ebus_cs_n_o, .ebus_ale_o, .ebus_rd_n_o,
  .ebus_wr_n_o, .ebus_data_oe_o, .bus_reference_clock_out_o);

/* File: dv/ebt_ext_mem.sv */
// behavioural memory on the far side of the external bus
module ebt_ext_mem (
  input  wire logic        clock_i,
  input  wire logic [1:0]  cs_n_i,
  input  wire logic        rd_n_i,
  input  wire logic        wr_n_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        ready_pol_i,
  input  wire logic [7:0]  ready_dly_i,
  output wire logic [15:0] rdata_o,
  output wire logic        ready_o,
  output logic      [15:0] wr_seen_o
);
  logic [15:0] idle_pat = 16'h0f0f;
  logic [7:0]  wait_n = 8'h00;
  logic        rdy_on = 1'b0;
  wire         sel = (cs_n_i != 2'b11);
  // released lines toggle so a stale sample never passes
  assign rdata_o = (sel && !rd_n_i) ? (addr_i[15:0] ^ 16'h5a5a) : idle_pat;
  assign ready_o = rdy_on ? ready_pol_i : !ready_pol_i;
  ////////////////////////////////////////
  always @(posedge clock_i) begin
    idle_pat <= ~idle_pat;
    if (rd_n_i && wr_n_i) begin
      wait_n <= 8'h00;
      rdy_on <= 1'b0;
    end else if (wait_n == ready_dly_i) begin
      rdy_on <= 1'b1;
    end else begin
      wait_n <= wait_n + 8'h01;
    end
    if (sel && !wr_n_i) wr_seen_o <= wdata_i;
  end
endmodule // ebt_ext_mem

/* File: dv/tb.sv */
// self-checking bench for the external bus sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
  logic [23:0] ebus_addr_o;
  logic [15:0] ebus_data_o, ebus_data_i, wr_seen;
  logic        ebus_data_oe_o, ebus_ale_o, ebus_rd_n_o, ebus_wr_n_o, ebus_ready_i;
  logic        bus_reference_clock_out_o, last_cs = 1'b0, rdy_pol = 1'b0;
  logic [1:0]  ebus_cs_n_o;
  logic [7:0]  rdy_dly = 8'h00;
  int          num_errors = 0, cmp_count = 0, cyc_n = 0, ab_n, cd_n, e_n, f_n, ref_n, e, e_s;
  logic [15:0] cfgs [8] = '{16'h0000, 16'h07ff, 16'hc222, 16'hc222, 16'h8419, 16'h1820,
                            16'h2820, 16'h1830};
  logic        wrs [8] = '{0, 1, 0, 0, 1, 0, 0, 0};
  logic        css [8] = '{0, 0, 1, 1, 0, 0, 0, 0};
  logic [7:0]  dlys [8] = '{0, 0, 0, 0, 0, 0, 0, 40};
  always #4 clock_i = ~clock_i;
  ebt_bus_ctrl dut (.clock_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .ebus_addr_o, .ebus_data_o,
    .ebus_data_oe_o, .ebus_data_i, .ebus_cs_n_o, .ebus_ale_o, .ebus_rd_n_o, .ebus_wr_n_o,
    .ebus_ready_i, .bus_reference_clock_out_o);
  ebt_ext_mem mem (.clock_i, .cs_n_i(ebus_cs_n_o), .rd_n_i(ebus_rd_n_o), .wr_n_i(ebus_wr_n_o),
    .addr_i(ebus_addr_o), .wdata_i(ebus_data_o), .ready_pol_i(rdy_pol),
    .ready_dly_i(rdy_dly), .rdata_o(ebus_data_i), .ready_o(ebus_ready_i), .wr_seen_o(wr_seen));
  ////////////////////////////////////////
  // phase lengths in clocks, taken from the pins of the running cycle
  always @(posedge clock_i) begin
    cyc_n++;
    if (bus_reference_clock_out_o === 1'b1) ref_n++;
    if (ebus_cs_n_o != 2'b11) begin
      if (ebus_ale_o) ab_n++;
      else if (!(ebus_rd_n_o && ebus_wr_n_o)) e_n++;
      else if (e_n == 0) cd_n++;
      else f_n++;
    end
    if (cyc_n == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= wd;
    do begin
      @(posedge clock_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    @(posedge clock_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(nm, ex, x);
  endtask
  // one external cycle; lengths compared in clocks, two per step
  task automatic run(input logic [15:0] c, input logic w, input logic cs, input logic [7:0] d);
    int n;
    logic [31:0] x;
    n = 0;
    wr({5'h0, cs, 2'h0}, {16'h0, c});
    rdchk("tcfg", {5'h0, cs, 2'h0}, {16'h0, c});
    wr(8'h10, {16'h0, ~c});
    wr(8'h1c, 32'h2);
    rdy_pol <= c[12];
    rdy_dly <= d;
    {ab_n, cd_n, e_n, f_n} = 128'h0;
    wr(8'h14, {30'h0, cs, w});
    do begin
      xfer(1'b0, 8'h1c, 32'h0, x);
      n++;
    end while (x[1] !== 1'b1 && n < 100);
    chk("status", {29'h0, cs, 2'b10}, x);
    chk("setup", 2 * (1 + c[0] + (cs != last_cs ? c[15:14] : 0)), ab_n);
    chk("cmd delay", 2 * (c[2:1] + c[3]), cd_n);
    chk("hold", 2 * c[10:9], f_n);
    if (!c[11]) chk("access", 2 * (c[8:4] + 1), e_n);
    if (w) chk("write data", {16'h0, ~c}, {16'h0, wr_seen});
    else rdchk("read data", 8'h18, 32'h0000fb99);
    last_cs = cs;
    e = e_n;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rdchk("tcfg0", 8'h00, 32'h0);
    rdchk("ctrl", 8'h08, 32'h0);
    wr(8'h40, 32'hffff);
    rdchk("unmapped", 8'h40, 32'h0);
    wr(8'h0c, 32'h00a1c3);
    for (int i = 0; i < 8; i++) begin
      run(cfgs[i], wrs[i], css[i], dlys[i]);
      if (cfgs[i][11]) chk("ready wait", 1, e > dlys[i] && e <= dlys[i] + 10 && !e[0]);
      if (i == 6) chk("async wait", 1, e >= e_s + 2);
      e_s = e;
    end
    wr(8'h08, 32'h1);
    @(negedge clock_i) ref_n = 0;
    repeat (20) @(negedge clock_i);
    chk("refclk on", 10, ref_n);
    wr(8'h08, 32'h0);
    @(negedge clock_i) ref_n = 0;
    repeat (20) @(negedge clock_i);
    chk("refclk off", 0, ref_n);
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rdchk("tcfg1", 8'h04, 32'h0);
    complete_run();
  end
endmodule // tb
